// *** common/sfpi_defs.svh ***
// Constants for the serial flash pin interface
`ifndef SFPI_DEFS_SVH
`define SFPI_DEFS_SVH
`define SFPI_ARRAY_BITS 16777216
`define SFPI_BUF_BYTES 256
`define SFPI_ADDR_W 21
`define SFPI_REG_CTRL 12'h000
`define SFPI_REG_STAT 12'h004
`define SFPI_REG_PROT 12'h008
`define SFPI_REG_BUF 12'h00c
`define SFPI_CTRL_QE 0
`define SFPI_CTRL_BUSY 1
`define SFPI_PROT_BP_LSB 0
`define SFPI_PROT_TB 3
`define SFPI_PROT_SIZE 4
`define SFPI_PROT_CMP 5
`define SFPI_PROT_RESET 6'h00
`define SFPI_BUSY_NS 1000
`define SFPI_CLK_NS 25
`define SFPI_BUSY_CYC ((`SFPI_BUSY_NS + `SFPI_CLK_NS - 1) / `SFPI_CLK_NS)
`endif

// *** common/sfpi_pkg.sv ***
// Types for the serial flash pin interface
package sfpi_pkg;
    typedef enum logic [2:0] {
        SFPI_IDLE, SFPI_CMD, SFPI_ADDR, SFPI_WDATA, SFPI_RDATA, SFPI_BUSY
    } sfpi_state_type;
    typedef enum logic [1:0] {
        SFPI_W1, SFPI_W2, SFPI_W4
    } sfpi_width_type;
    typedef struct packed {
        logic [3:0] o;
        logic [3:0] oe;
    } sfpi_pins_type;
    typedef struct packed {
        logic [2:0] range_field;
        logic top_bottom;
        logic granule_size;
        logic complement;
    } sfpi_prot_type;
endpackage : sfpi_pkg

// *** hdl/sfpi_core.sv ***
// Serial flash pin interface with APB side registers
// Notes on behaviour
// - Select high deselects to standby and floats the serial output.
// - While deselected the serial input is ignored.
// - Select fall starts an operation, select rise ends it.
// - A program ended by select rise stays active until done.
// - Command, address and write data are sampled on clock rise.
// - Output bits are launched on clock fall.
// - Multi-line reads turn the input line into driven data line zero.
// - Multi-line reads keep the output line driving as data line one.
// - Write-protect asserted rejects status register writes.
// - Write-protect and protect fields decide which regions are locked.
// - Quad enable turns write-protect into data line two.
// - The device holds a 16 Mbit array and a 256-byte buffer.
// - Hold ignores clock and input and floats output, keeps selection.
// - Quad enable makes line three data, with no hold function.
`timescale 1ns/1ps
`include "sfpi_defs.svh"
module sfpi_core #(
    parameter int BUSY_CYC = `SFPI_BUSY_CYC,
    parameter int BUF_BYTES = `SFPI_BUF_BYTES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic [3:0] io_i,
    output sfpi_pkg::sfpi_pins_type io_r,
    output logic standby_r
);
    typedef struct packed {
        sfpi_pkg::sfpi_state_type st;
        sfpi_pkg::sfpi_width_type wd;
        logic sck_q;
        logic cs_q;
        logic [7:0] cmd;
        logic [4:0] cnt;
        logic [`SFPI_ADDR_W-1:0] addr;
        logic [7:0] sh;
        logic [15:0] busy_cnt;
        logic qe;
        sfpi_pkg::sfpi_prot_type prot;
        sfpi_pkg::sfpi_pins_type pins;
        logic standby;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic wp_rej;
        logic prog;
        logic [3:0] oe_keep;
    } sfpi_core_type;

    sfpi_core_type s_r, s_nxt;
    logic [7:0] buf_mem [BUF_BYTES];
    logic buf_we;
    logic [7:0] buf_wa;
    logic [7:0] buf_wd;
    logic [7:0] rbyte;
    logic locked;
    logic sck_rise, sck_fall, hold_on, wp_on;
    logic [3:0] din;

    // Status register writes use opcode 01h, program 02h, reads 03h/3bh/6bh
    localparam logic [7:0] OP_WSR = 8'h01;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_RD = 8'h03;
    localparam logic [7:0] OP_RD2 = 8'h3b;
    localparam logic [7:0] OP_RD4 = 8'h6b;

    sfpi_prot_check u_prot (
        .addr(s_r.addr),
        .prot(s_r.prot),
        .wp_active(wp_on),
        .locked(locked)
    );

    assign rbyte = buf_mem[s_r.addr[7:0]];

    always_comb
    begin
        s_nxt = s_r;
        buf_we = 1'b0;
        buf_wa = s_r.addr[7:0];
        buf_wd = s_r.sh;
        wp_on = !s_r.qe && !io_i[2];
        hold_on = !s_r.qe && !io_i[3] && !s_r.pins.oe[3];
        din = io_i;
        // Skipping the first pclk edge after select fall avoids a false rise
        sck_rise = sck && !s_r.sck_q && !s_r.cs_q && !hold_on;
        sck_fall = !sck && s_r.sck_q && !s_r.cs_q && !hold_on;
        s_nxt.sck_q = sck;
        s_nxt.cs_q = cs_n;
        s_nxt.ready = 1'b0;
        s_nxt.err = 1'b0;
        // APB: one wait state, answer in the access phase's second cycle
        if (psel && penable && !s_r.ready)
        begin
            s_nxt.ready = 1'b1;
            s_nxt.rdata = 32'h0000_0000;
            case (paddr)
                `SFPI_REG_CTRL:
                begin
                    s_nxt.rdata[`SFPI_CTRL_QE] = s_r.qe;
                    s_nxt.rdata[`SFPI_CTRL_BUSY] = (s_r.st == sfpi_pkg::SFPI_BUSY);
                end
                `SFPI_REG_STAT:
                    s_nxt.rdata = {27'h0, s_r.wp_rej, s_r.standby,
                                   wp_on, locked, hold_on};
                `SFPI_REG_PROT:
                begin
                    s_nxt.rdata[5:0] = s_r.prot;
                end
                `SFPI_REG_BUF:
                    s_nxt.rdata[7:0] = rbyte;
                default:
                    s_nxt.err = 1'b1;
            endcase
        end
        // Writes land only at the edge where ready is seen high
        if (psel && penable && s_r.ready && pwrite)
        begin
            case (paddr)
                `SFPI_REG_CTRL:
                    s_nxt.qe = pwdata[`SFPI_CTRL_QE];
                `SFPI_REG_PROT:
                    s_nxt.prot = sfpi_pkg::sfpi_prot_type'(pwdata[5:0]);
                default:
                    s_nxt.err = 1'b0;
            endcase
        end
        if (cs_n)
        begin
            // Deselected: output floats, input ignored
            s_nxt.pins.oe = 4'h0;
            s_nxt.oe_keep = 4'h0;
            s_nxt.cnt = 5'h00;
            if (!s_r.cs_q && s_r.prog && s_r.st != sfpi_pkg::SFPI_IDLE)
            begin
                s_nxt.st = sfpi_pkg::SFPI_BUSY;
                s_nxt.busy_cnt = 16'(BUSY_CYC);
            end
            else if (s_r.st != sfpi_pkg::SFPI_BUSY)
                s_nxt.st = sfpi_pkg::SFPI_IDLE;
        end
        else if (s_r.cs_q && s_r.st == sfpi_pkg::SFPI_IDLE)
        begin
            s_nxt.st = sfpi_pkg::SFPI_CMD;
            s_nxt.cnt = 5'h00;
            s_nxt.wd = sfpi_pkg::SFPI_W1;
            s_nxt.prog = 1'b0;
        end
        if (hold_on && !cs_n)
            s_nxt.pins.oe = 4'h0;
        else if (!cs_n && s_r.st == sfpi_pkg::SFPI_RDATA)
            s_nxt.pins.oe = s_r.oe_keep;
        case (s_r.st)
            sfpi_pkg::SFPI_IDLE:
                s_nxt.standby = 1'b1;
            sfpi_pkg::SFPI_CMD:
            begin
                s_nxt.standby = 1'b0;
                if (sck_rise && !cs_n)
                begin
                    s_nxt.cmd = {s_r.cmd[6:0], din[0]};
                    s_nxt.cnt = s_r.cnt + 5'h01;
                    if (s_r.cnt == 5'h07)
                    begin
                        s_nxt.cnt = 5'h00;
                        if ({s_r.cmd[6:0], din[0]} == OP_WSR)
                        begin
                            s_nxt.st = sfpi_pkg::SFPI_WDATA;
                            s_nxt.wp_rej = wp_on;
                        end
                        else
                            s_nxt.st = sfpi_pkg::SFPI_ADDR;
                    end
                end
            end
            sfpi_pkg::SFPI_ADDR:
                if (sck_rise && !cs_n)
                begin
                    s_nxt.addr = {s_r.addr[`SFPI_ADDR_W-2:0], din[0]};
                    s_nxt.cnt = s_r.cnt + 5'h01;
                    if (s_r.cnt == 5'd23)
                    begin
                        s_nxt.cnt = 5'h00;
                        case (s_r.cmd)
                            OP_PROG: s_nxt.st = sfpi_pkg::SFPI_WDATA;
                            OP_RD2:
                            begin
                                s_nxt.st = sfpi_pkg::SFPI_RDATA;
                                s_nxt.wd = sfpi_pkg::SFPI_W2;
                            end
                            OP_RD4:
                            begin
                                s_nxt.st = sfpi_pkg::SFPI_RDATA;
                                s_nxt.wd = s_r.qe ? sfpi_pkg::SFPI_W4
                                                  : sfpi_pkg::SFPI_W1;
                            end
                            default: s_nxt.st = sfpi_pkg::SFPI_RDATA;
                        endcase
                    end
                end
            sfpi_pkg::SFPI_WDATA:
                if (sck_rise && !cs_n)
                begin
                    s_nxt.sh = {s_r.sh[6:0], din[0]};
                    s_nxt.cnt = s_r.cnt + 5'h01;
                    if (s_r.cnt == 5'h07)
                    begin
                        s_nxt.cnt = 5'h00;
                        if (s_r.cmd == OP_WSR)
                        begin
                            if (!s_r.wp_rej && !wp_on)
                            begin
                                s_nxt.qe = s_r.sh[`SFPI_CTRL_QE];
                                s_nxt.prot = sfpi_pkg::sfpi_prot_type'(
                                    {s_r.sh[4:0], din[0]});
                            end
                            else
                                s_nxt.wp_rej = 1'b1;
                        end
                        else if (!locked)
                        begin
                            buf_we = 1'b1;
                            buf_wd = {s_r.sh[6:0], din[0]};
                            s_nxt.prog = 1'b1;
                            s_nxt.addr[7:0] = s_r.addr[7:0] + 8'h01;
                        end
                    end
                end
            sfpi_pkg::SFPI_RDATA:
                if (sck_fall && !cs_n)
                begin
                    s_nxt.pins.oe = 4'h2;
                    case (s_r.wd)
                        sfpi_pkg::SFPI_W2:
                        begin
                            s_nxt.pins.oe = 4'h3;
                            s_nxt.pins.o[1:0] = rbyte[3'(7 - 2*s_r.cnt[1:0]) -: 2];
                            s_nxt.cnt = {3'h0, s_r.cnt[1:0] + 2'h1};
                            if (s_r.cnt[1:0] == 2'h3)
                                s_nxt.addr = s_r.addr + 1'b1;
                        end
                        sfpi_pkg::SFPI_W4:
                        begin
                            s_nxt.pins.oe = 4'hf;
                            s_nxt.pins.o = s_r.cnt[0] ? rbyte[3:0] : rbyte[7:4];
                            s_nxt.cnt = {4'h0, ~s_r.cnt[0]};
                            if (s_r.cnt[0])
                                s_nxt.addr = s_r.addr + 1'b1;
                        end
                        default:
                        begin
                            s_nxt.pins.o[1] = rbyte[3'(7 - s_r.cnt[2:0])];
                            s_nxt.cnt = {2'h0, s_r.cnt[2:0] + 3'h1};
                            if (s_r.cnt[2:0] == 3'h7)
                                s_nxt.addr = s_r.addr + 1'b1;
                        end
                    endcase
                    // Remembered so a released hold drives the lines again
                    s_nxt.oe_keep = s_nxt.pins.oe;
                end
            sfpi_pkg::SFPI_BUSY:
            begin
                s_nxt.standby = 1'b0;
                if (s_r.busy_cnt <= 16'h0001)
                begin
                    s_nxt.st = sfpi_pkg::SFPI_IDLE;
                    s_nxt.prog = 1'b0;
                end
                else
                    s_nxt.busy_cnt = s_r.busy_cnt - 16'h0001;
            end
            default: s_nxt.st = sfpi_pkg::SFPI_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r <= '0;
            s_r.st <= sfpi_pkg::SFPI_IDLE;
            s_r.cs_q <= 1'b1;
            s_r.standby <= 1'b1;
            s_r.prot <= sfpi_pkg::sfpi_prot_type'(`SFPI_PROT_RESET);
        end
        else
            s_r <= s_nxt;
    end

    always_ff @(posedge pclk)
    begin
        if (buf_we)
            buf_mem[buf_wa] <= buf_wd;
    end

    assign prdata = s_r.rdata;
    assign pready = s_r.ready;
    assign pslverr = s_r.err;
    assign io_r = s_r.pins;
    assign standby_r = s_r.standby;
endmodule : sfpi_core

// *** hdl/sfpi_prot_check.sv ***
// Hardware protection decision for one array address
`timescale 1ns/1ps
`include "sfpi_defs.svh"
module sfpi_prot_check #(
    parameter int ADDR_W = `SFPI_ADDR_W
) (
    input wire logic [ADDR_W-1:0] addr,
    input wire sfpi_pkg::sfpi_prot_type prot,
    input wire logic wp_active,
    output logic locked
);
    logic [2:0] sect;
    logic in_range;
    // Range selects 1..7 eighths (or sixty-fourths when granule is small)
    always_comb
    begin
        sect = prot.top_bottom ? addr[ADDR_W-1 -: 3] : ~addr[ADDR_W-1 -: 3];
        if (prot.granule_size)
            in_range = (prot.range_field != 3'h0) &&
                       (3'(~sect) < prot.range_field);
        else
            in_range = (prot.range_field != 3'h0) &&
                       (3'(~sect) == 3'h0) &&
                       (addr[ADDR_W-4 -: 3] >= 3'(~prot.range_field + 3'h1));
        locked = wp_active & (in_range ^ prot.complement);
    end
endmodule : sfpi_prot_check

// *** tb/serial_flash_pin_interface_test.sv ***
// Testbench for the serial flash pin interface
`timescale 1ns/1ps
module serial_flash_pin_interface_test;
    typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic e;}
        sfpi_row_type;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic pready, pslverr, e, cs_n, sck, standby_r;
    logic [3:0] io_i;
    logic [7:0] b;
    sfpi_pkg::sfpi_pins_type io_r;
    int n_fail = 0;
    int compares = 0;
    sfpi_row_type rows [9] = '{
        '{0, 12'h000, 32'h0, 0}, '{0, 12'h008, 32'h0, 0},
        '{1, 12'h008, 32'h2a, 0}, '{0, 12'h008, 32'h2a, 0},
        '{1, 12'h008, 32'h0, 0}, '{1, 12'h000, 32'h1, 0},
        '{0, 12'h000, 32'h1, 0}, '{1, 12'h000, 32'h0, 0},
        '{0, 12'h010, 32'h0, 1}};
    sfpi_core #(.BUSY_CYC(4)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cs_n(cs_n), .sck(sck), .io_i(io_i),
        .io_r(io_r), .standby_r(standby_r));
    sfpi_host_model HM (.pclk(pclk), .io_r(io_r), .cs_n(cs_n),
        .sck(sck), .io_i(io_i));
    initial
    begin
        forever #12.5 pclk = ~pclk;
    end
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 50)
        begin
            @(posedge pclk);
            k++;
        end
        if (k >= 50) n_fail++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd_op(input logic [7:0] op, input int w, input int n);
        HM.sel(1'b0);
        HM.send(op);
        repeat (3) HM.send(8'h00);
        HM.recv(w, n, b);
        HM.desel();
    endtask : rd_op
    task stop_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    initial
    begin
        #(25 * 20000);
        n_fail++;
        stop_test();
    end
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("standby", 1, standby_r);
        chk("oe", 0, io_r.oe);
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk("err", rows[i].e, e);
            if (!rows[i].w && !rows[i].e) chk("reg", rows[i].d, r);
        end
        $display("register rows done");
        HM.sel(1'b0);
        HM.send(8'h02);
        repeat (3) HM.send(8'h00);
        HM.send(8'ha5);
        HM.tick(2);
        HM.cs_n <= 1'b1;
        HM.tick(2);
        #1;
        chk("busy standby", 0, standby_r);
        for (int k = 0; k < 20 && standby_r !== 1'b1; k++) HM.tick(1);
        #1;
        chk("done standby", 1, standby_r);
        HM.sel(1'b1);
        HM.send(8'h03);
        repeat (3) HM.send(8'h00);
        HM.recv(1, 8, b);
        HM.desel();
        chk("single read", 8'ha5, b);
        rd_op(8'h3b, 2, 4);
        chk("dual read", 8'ha5, b);
        apb(1'b1, 12'h000, 32'h1);
        rd_op(8'h6b, 4, 2);
        chk("quad read", 8'ha5, b);
        apb(1'b1, 12'h000, 32'h0);
        $display("transfer tests done");
        HM.sel(1'b0);
        HM.send(8'h03);
        repeat (3) HM.send(8'h00);
        HM.sck <= 1'b0;
        HM.tick(4);
        HM.hold_lvl <= 1'b0;
        HM.tick(4);
        chk("hold float", 0, io_r.oe[1]);
        HM.hold_lvl <= 1'b1;
        HM.tick(2);
        r[0] = io_i[1];
        HM.sck <= 1'b1;
        HM.tick(4);
        HM.recv(1, 7, b);
        HM.desel();
        chk("hold resume", 8'ha5, {r[0], b[6:0]});
        HM.wp_lvl <= 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            HM.sel(1'b0);
            HM.send(8'h01);
            HM.send(8'h3c);
            HM.desel();
            apb(1'b0, 12'h008, 32'h0);
            chk("protect", k ? 32'h3c : 32'h0, r);
            HM.wp_lvl <= 1'b1;
        end
        apb(1'b1, 12'h008, 32'h0);
        $display("protect tests done");
        stop_test();
    end
endmodule : serial_flash_pin_interface_test

// *** tb/sfpi_core_monitor.sv ***
// Port checker for the serial flash pin interface
`timescale 1ns/1ps
module sfpi_core_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic [3:0] io_i,
    input wire sfpi_pkg::sfpi_pins_type io_r,
    input wire logic standby_r
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    desel_float_a: assert property (cs_n && $past(cs_n) |-> io_r.oe == 4'h0)
        else $error("output driven while deselected");
    sel_wake_a: assert property ($fell(cs_n) |-> ##[1:3] !standby_r)
        else $error("no wake after select fall");
    fall_launch_a: assert property ($changed(io_r.o[1]) && io_r.oe[1] && $past(io_r.oe[1]) |-> !sck)
        else $error("output changed outside clock low phase");
    line0_dual_a: assert property (io_r.oe[0] |-> io_r.oe[1])
        else $error("line zero driven without line one");
    quad_lines_a: assert property (io_r.oe[2] |-> io_r.oe[0] && io_r.oe[3])
        else $error("line two driven outside quad read");
    hold_float_a: assert property (!io_i[3] && !io_r.oe[3] && $past(!io_i[3]) [*2] |-> !io_r.oe[1])
        else $error("output driven during hold");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("ready without access");
    err_mapped_a: assert property (pready && paddr <= 12'h00c |-> !pslverr)
        else $error("error on mapped address");
endmodule : sfpi_core_monitor
bind sfpi_core sfpi_core_monitor u_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .cs_n(cs_n), .sck(sck), .io_i(io_i), .io_r(io_r),
    .standby_r(standby_r));

// *** tb/sfpi_host_model.sv ***
// Host controller model driving select, clock and data pins
`timescale 1ns/1ps
module sfpi_host_model (
    input wire logic pclk,
    input wire sfpi_pkg::sfpi_pins_type io_r,
    output logic cs_n,
    output logic sck,
    output logic [3:0] io_i
);
    logic si = 1'b1;
    logic flt = 1'b0;
    logic wp_lvl = 1'b1;
    logic hold_lvl = 1'b1;
    initial cs_n = 1'b1;
    initial sck = 1'b0;
    // Released line one shows a changing pattern, not its last value
    always @(posedge pclk) flt <= ~flt;
    assign io_i = {io_r.oe[3] ? io_r.o[3] : hold_lvl,
                   io_r.oe[2] ? io_r.o[2] : wp_lvl,
                   io_r.oe[1] ? io_r.o[1] : flt,
                   io_r.oe[0] ? io_r.o[0] : si};
    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    // Clock idle level chosen before select falls
    task sel(input logic idle);
        sck <= idle;
        tick(2);
        cs_n <= 1'b0;
        tick(4);
    endtask : sel
    task desel;
        tick(2);
        cs_n <= 1'b1;
        tick(4);
    endtask : desel
    // Four pclk per half period keeps the clock under pclk/4
    task send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            sck <= 1'b0;
            si <= b[i];
            tick(4);
            sck <= 1'b1;
            tick(4);
        end
    endtask : send
    task recv(input int w, input int n, output logic [7:0] b);
        b = 8'h00;
        repeat (n)
        begin
            sck <= 1'b0;
            tick(4);
            if (w == 1) b = {b[6:0], io_i[1]};
            else if (w == 2) b = {b[5:0], io_i[1:0]};
            else b = {b[3:0], io_i};
            sck <= 1'b1;
            tick(4);
        end
    endtask : recv
endmodule : sfpi_host_model
